//--- tb/asc_host.sv
`timescale 1ns/1ps

module asc_host (
    input wire logic clk_sys,
    output logic cfg_write,
    output logic [1:0] cfg_mode,
    output logic [1:0] cfg_clk_sel,
    output logic cfg_upper_zero
);
    initial begin
        cfg_write = 1'b0;
        cfg_mode = 2'h0;
        cfg_clk_sel = 2'h0;
        cfg_upper_zero = 1'b0;
    end

    // One completed serial write per call; fields are junk once the strobe drops
    task automatic wr(input logic [1:0] m, input logic [1:0] s, input logic z);
        @(negedge clk_sys);
        cfg_write = 1'b1;
        cfg_mode = m;
        cfg_clk_sel = s;
        cfg_upper_zero = z;
        @(negedge clk_sys);
        cfg_write = 1'b0;
        cfg_mode = ~m;
        cfg_clk_sel = ~s;
        cfg_upper_zero = ~z;
    endtask
endmodule

//--- tb/asc_top_tb_top.sv
`timescale 1ns/1ps
`include "asc_defs.svh"

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end

module asc_top_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cfg_write, cfg_upper_zero, spe = 1'b1, scont = 1'b0, sdone = 1'b0;
    logic [1:0] cfg_mode, cfg_clk_sel, ratio = 2'h0, st;
    logic [23:0] sdelay = 24'h00_0000;
    logic [8:0] sc, v;
    logic irq, crst, snext, gate, osc, pin, oe, last;
    int mismatches = 0;
    int total_checks = 0;
    int i, n;

    always #4 clk_sys = ~clk_sys;

    asc_host HOST (.clk_sys(clk_sys), .cfg_write(cfg_write), .cfg_mode(cfg_mode),
        .cfg_clk_sel(cfg_clk_sel), .cfg_upper_zero(cfg_upper_zero));

    asc_top #(.MOD_DIV(1)) DUT (.clk_sys(clk_sys), .reset(reset), .cfg_write(cfg_write),
        .cfg_mode(cfg_mode), .cfg_clk_sel(cfg_clk_sel), .cfg_upper_zero(cfg_upper_zero),
        .clock_divide_ratio(ratio), .start_pulse_enable(spe), .scan_continuous(scont),
        .scan_cycle_done(sdone), .scan_delay(sdelay), .adc_state(st), .settle_count(sc),
        .irq_pulse(irq), .conv_restart(crst), .scan_next(snext), .mclk_gate(gate),
        .osc_enable(osc), .clk_pin_out(pin), .clk_pin_oe(oe));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Settling takes about 512 cycles here, so 700 leaves margin without hiding a stall
    task automatic wait_conv();
        for (i = 0; i < 700 && st !== asc_pkg::ASC_CONV; i++) @(negedge clk_sys);
    endtask

    initial begin
        #(8 * 20000);
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        `CHK(st, asc_pkg::ASC_SHUT)
        `CHK(sc, `ASC_SETTLE_FULL)
        HOST.wr(2'h3, 2'h0, 1'b0);
        // State follows a mode write one cycle after the write edge
        @(negedge clk_sys);
        `CHK(st, asc_pkg::ASC_SETTLE)
        repeat (3) @(negedge clk_sys);
        `CHK(sc, `ASC_SETTLE_FULL)
        wait_conv();
        `CHK(irq, 1'b1)
        `CHK(sc, 9'h0000)
        HOST.wr(2'h2, 2'h0, 1'b0);
        @(negedge clk_sys);
        `CHK(st, asc_pkg::ASC_STBY)
        HOST.wr(2'h3, 2'h0, 1'b0);
        @(negedge clk_sys);
        `CHK(st, asc_pkg::ASC_CONV)
        HOST.wr(2'h0, 2'h0, 1'b0);
        `CHK(st, asc_pkg::ASC_SHUT)
        `CHK(sc, `ASC_SETTLE_FULL)
        HOST.wr(2'h2, 2'h0, 1'b0);
        repeat (40) @(negedge clk_sys);
        v = sc;
        HOST.wr(2'h2, 2'h0, 1'b0);
        // Two edges pass during the call, so exactly one tick may land; no reload allowed
        `CHK(sc <= v && sc + 9'h001 >= v, 1'b1)
        v = sc;
        repeat (2) @(negedge clk_sys);
        `CHK(sc, v)
        // Rewrite while the sync wait still runs: the wait must start over
        HOST.wr(2'h2, 2'h0, 1'b0);
        `CHK(sc, v)
        repeat (3) @(negedge clk_sys);
        `CHK(sc, v)
        HOST.wr(2'h3, 2'h0, 1'b0);
        `CHK(st, asc_pkg::ASC_SETTLE)
        wait_conv();
        `CHK(sc, 9'h0000)
        for (n = 3; n >= 0; n--) begin
            HOST.wr(2'h3, n[1:0], 1'b0);
            `CHK(oe, n == 3)
            `CHK(osc, n[1])
            `CHK(crst, 1'b1)
            `CHK(sc, `ASC_SETTLE_FULL)
        end
        HOST.wr(2'h3, 2'h3, 1'b0);
        for (n = 0; n < 4; n++) begin
            ratio = n[1:0];
            repeat (20) @(negedge clk_sys);
            v = 9'h000;
            last = pin;
            repeat (32) begin
                @(negedge clk_sys);
                v = v + (pin !== last);
                last = pin;
            end
            `CHK(v, 9'd32 >> n)
        end
        wait_conv();
        scont = 1'b1;
        sdelay = 24'd300;
        sdone = 1'b1;
        @(negedge clk_sys);
        sdone = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(st, asc_pkg::ASC_SHUT)
        for (n = 0; n < 300 && st === asc_pkg::ASC_SHUT; n++) @(negedge clk_sys);
        `CHK(n > 80 && n < 96, 1'b1)
        repeat (3) @(negedge clk_sys);
        `CHK(sc < `ASC_SETTLE_FULL, 1'b1)
        for (i = 0; i < 700 && snext !== 1'b1; i++) @(negedge clk_sys);
        `CHK(snext, 1'b1)
        sdelay = 24'd10;
        sdone = 1'b1;
        @(negedge clk_sys);
        sdone = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(st, asc_pkg::ASC_STBY)
        scont = 1'b0;
        HOST.wr(2'h0, 2'h0, 1'b1);
        `CHK(gate, 1'b0)
        `CHK(sc, `ASC_SETTLE_FULL)
        HOST.wr(2'h2, 2'h0, 1'b0);
        `CHK(gate, 1'b1)
        wrap_up();
    end
endmodule

//--- verilog/asc_defs.svh
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// Settling wait after leaving converter shutdown, in modulator periods
`define ASC_SETTLE_FULL 9'h0100
// Scan delays above this lead shut the converter down between cycles
`define ASC_SCAN_LEAD 24'h00_0100
// Host-write synchronisation wait, in master clock periods
`define ASC_SYNC_MCLK 4'h2
// System clock cycles per master clock period (master clock is clk_sys / 2)
`define ASC_SYS_PER_MCLK 4'h2
// Mode field codes
`define ASC_MODE_STBY 2'h2
`define ASC_MODE_CONV 2'h3
// Clock-select code for internal oscillator with divided clock driven out
`define ASC_SEL_OSC_OUT 2'h3
`endif

//--- verilog/asc_pkg.sv
package asc_pkg;
    typedef enum logic [1:0] {
        ASC_SHUT = 2'b00,
        ASC_SETTLE = 2'b01,
        ASC_STBY = 2'b10,
        ASC_CONV = 2'b11
    } asc_state_type;
endpackage

//--- verilog/asc_top.sv
// What this block does
// - Powered to shutdown takes effect immediately
// - Entering shutdown reloads settle counter to 256
// - Leaving shutdown counts settle down from 256
// - Host write power-up waits two master clocks
// - Sequencer power-up counts with no wait
// - At zero: mode 10 ready, 11 converts
// - Standby and conversion swap one cycle after write at zero, with no sync wait
// - Conversion requested early waits for zero
// - Same-mode rewrite reloads settle counter only on clock-select change
// - Each powered-mode rewrite restarts sync wait
// - Long scan delay: shut down, wake 256 early
// - Short scan delay: stay in standby
// - Optional pulse on each conversion start
// - Decode clock-select into source and pin
// - Full shutdown stops master clock distribution
// - Clock-select change restarts conversions and phases
// - Oscillator runs unless clock-select is 0x
// - Pin carries master clock divided by 2 to the power of divide ratio
// - Divided clock appears right after write
// - Full shutdown halts all timers and clears all but the settle counter, held at 256
`timescale 1ns/1ps
`include "asc_defs.svh"

module asc_top #(
    parameter int MOD_DIV = 4
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cfg_write,
    input wire logic [1:0] cfg_mode,
    input wire logic [1:0] cfg_clk_sel,
    input wire logic cfg_upper_zero,
    input wire logic [1:0] clock_divide_ratio,
    input wire logic start_pulse_enable,
    input wire logic scan_continuous,
    input wire logic scan_cycle_done,
    input wire logic [23:0] scan_delay,
    output logic [1:0] adc_state,
    output logic [8:0] settle_count,
    output logic irq_pulse,
    output logic conv_restart,
    output logic scan_next,
    output logic mclk_gate,
    output logic osc_enable,
    output logic clk_pin_out,
    output logic clk_pin_oe
);

    localparam logic [3:0] SYNC_CYCLES = 4'(`ASC_SYNC_MCLK * `ASC_SYS_PER_MCLK);
    localparam logic [7:0] MOD_LAST = 8'(MOD_DIV - 1);

    // Pin half period in clk_sys cycles; one full pin period is 2 to the power of the ratio in master clocks
    function automatic logic [7:0] pin_half(input logic [1:0] ratio);
        pin_half = 8'h01 << ratio;
    endfunction

    asc_pkg::asc_state_type state_q, state_d;
    logic [1:0] mode_q, mode_d;
    logic [1:0] clk_sel_q, clk_sel_d;
    logic full_q, full_d;
    logic [8:0] settle_q, settle_d;
    logic [3:0] sync_q, sync_d;
    logic scan_off_q, scan_off_d;
    logic scan_hold_q, scan_hold_d;
    logic [23:0] scan_wait_q, scan_wait_d;
    logic irq_q, irq_d;
    logic restart_q, restart_d;
    logic scan_next_q, scan_next_d;
    logic mclk_ph_q, mclk_ph_d;
    logic [7:0] mod_cnt_q, mod_cnt_d;
    logic [7:0] pin_cnt_q, pin_cnt_d;
    logic pin_q, pin_d;
    logic pin_oe_q, pin_oe_d;
    logic osc_q, osc_d;
    logic gate_q, gate_d;

    logic sel_change;
    logic full_enter;
    logic mclk_tick;
    logic mod_tick;
    logic [1:0] eff_mode;
    logic powered;

    assign sel_change = cfg_write && (cfg_clk_sel != clk_sel_q);
    assign full_enter = cfg_write && cfg_upper_zero && (cfg_clk_sel == 2'h0)
                        && (cfg_mode == 2'h0);
    assign mclk_tick = mclk_ph_q && !full_q;
    assign mod_tick = mclk_tick && (mod_cnt_q == MOD_LAST);
    assign eff_mode = scan_off_q ? 2'h0 : (scan_hold_q ? `ASC_MODE_STBY : mode_q);
    assign powered = eff_mode[1] && !full_q;

    // Clock generation and pin drive
    always_comb begin
        mclk_ph_d = mclk_ph_q;
        mod_cnt_d = mod_cnt_q;
        pin_cnt_d = pin_cnt_q;
        pin_d = pin_q;
        if (!full_q) begin
            // Distribution stops in full shutdown; counters freeze cleared below
            mclk_ph_d = !mclk_ph_q;
            if (mclk_tick) begin
                mod_cnt_d = (mod_cnt_q == MOD_LAST) ? 8'h00 : mod_cnt_q + 8'h01;
            end
            if (clk_sel_q == `ASC_SEL_OSC_OUT) begin
                if (pin_cnt_q >= pin_half(clock_divide_ratio) - 8'h01) begin
                    pin_cnt_d = 8'h00;
                    pin_d = !pin_q;
                end else begin
                    pin_cnt_d = pin_cnt_q + 8'h01;
                end
            end
        end
        if (full_enter || sel_change) begin
            // Phases restart from defaults; may stretch one pin phase
            mclk_ph_d = 1'b0;
            mod_cnt_d = 8'h00;
            pin_cnt_d = 8'h00;
            pin_d = 1'b0;
        end
        clk_sel_d = cfg_write ? cfg_clk_sel : clk_sel_q;
        pin_oe_d = (clk_sel_d == `ASC_SEL_OSC_OUT);
        osc_d = clk_sel_d[1];
        full_d = cfg_write ? full_enter : full_q;
        gate_d = !full_d;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mclk_ph_q <= 1'b0;
            mod_cnt_q <= 8'h00;
            pin_cnt_q <= 8'h00;
            pin_q <= 1'b0;
            clk_sel_q <= 2'h0;
            pin_oe_q <= 1'b0;
            osc_q <= 1'b0;
            full_q <= 1'b0;
            gate_q <= 1'b1;
        end else begin
            mclk_ph_q <= mclk_ph_d;
            mod_cnt_q <= mod_cnt_d;
            pin_cnt_q <= pin_cnt_d;
            pin_q <= pin_d;
            clk_sel_q <= clk_sel_d;
            pin_oe_q <= pin_oe_d;
            osc_q <= osc_d;
            full_q <= full_d;
            gate_q <= gate_d;
        end
    end

    // Power sequencing, settling counter and scan delay
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        settle_d = settle_q;
        sync_d = sync_q;
        scan_off_d = scan_off_q;
        scan_hold_d = scan_hold_q;
        scan_wait_d = scan_wait_q;
        restart_d = 1'b0;
        scan_next_d = 1'b0;
        if (!powered) begin
            state_d = asc_pkg::ASC_SHUT;
            settle_d = `ASC_SETTLE_FULL;
            sync_d = 4'h0;
        end else begin
            if (sync_q != 4'h0) begin
                sync_d = sync_q - 4'h1;
            end else if (mod_tick && settle_q != 9'h000) begin
                settle_d = settle_q - 9'h001;
            end
            if (settle_q == 9'h000) begin
                state_d = eff_mode[0] ? asc_pkg::ASC_CONV : asc_pkg::ASC_STBY;
            end else begin
                state_d = asc_pkg::ASC_SETTLE;
            end
        end
        if (full_q) begin
            scan_off_d = 1'b0;
            scan_hold_d = 1'b0;
            scan_wait_d = 24'h00_0000;
        end else if (scan_cycle_done && scan_continuous && mode_q == `ASC_MODE_CONV) begin
            scan_wait_d = scan_delay;
            scan_hold_d = (scan_delay != 24'h00_0000);
            scan_off_d = (scan_delay > `ASC_SCAN_LEAD);
            scan_next_d = (scan_delay == 24'h00_0000);
        end else if (scan_hold_q && mod_tick) begin
            scan_wait_d = scan_wait_q - 24'h00_0001;
            // Waking inside the sequencer skips the host sync wait
            scan_off_d = (scan_wait_d > `ASC_SCAN_LEAD);
            if (scan_wait_q == 24'h00_0001) begin
                scan_hold_d = 1'b0;
                scan_next_d = 1'b1;
            end
        end
        if (cfg_write) begin
            mode_d = cfg_mode;
            scan_off_d = 1'b0;
            scan_hold_d = 1'b0;
            scan_wait_d = 24'h00_0000;
            if (cfg_mode[1] && !full_enter) begin
                // Settle count untouched: a rewrite cannot shorten the wait
                sync_d = SYNC_CYCLES;
            end else begin
                state_d = asc_pkg::ASC_SHUT;
                settle_d = `ASC_SETTLE_FULL;
                sync_d = 4'h0;
            end
            if (sel_change) begin
                restart_d = 1'b1;
                settle_d = `ASC_SETTLE_FULL;
                state_d = asc_pkg::ASC_SHUT;
            end
        end
        irq_d = start_pulse_enable && state_q != asc_pkg::ASC_CONV
                && state_d == asc_pkg::ASC_CONV;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= asc_pkg::ASC_SHUT;
            mode_q <= 2'h0;
            settle_q <= `ASC_SETTLE_FULL;
            sync_q <= 4'h0;
            scan_off_q <= 1'b0;
            scan_hold_q <= 1'b0;
            scan_wait_q <= 24'h00_0000;
            irq_q <= 1'b0;
            restart_q <= 1'b0;
            scan_next_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            settle_q <= settle_d;
            sync_q <= sync_d;
            scan_off_q <= scan_off_d;
            scan_hold_q <= scan_hold_d;
            scan_wait_q <= scan_wait_d;
            irq_q <= irq_d;
            restart_q <= restart_d;
            scan_next_q <= scan_next_d;
        end
    end

    assign adc_state = state_q;
    assign settle_count = settle_q;
    assign irq_pulse = irq_q;
    assign conv_restart = restart_q;
    assign scan_next = scan_next_q;
    assign mclk_gate = gate_q;
    assign osc_enable = osc_q;
    assign clk_pin_out = pin_q;
    assign clk_pin_oe = pin_oe_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_shut_immediate: assert property (cfg_write && !cfg_mode[1]
        |=> state_q == asc_pkg::ASC_SHUT && settle_q == `ASC_SETTLE_FULL)
        else $error("shutdown write did not act at once");
    a_shut_reload: assert property (state_q == asc_pkg::ASC_SHUT && !cfg_write
        |-> settle_q == `ASC_SETTLE_FULL)
        else $error("settle counter not full in shutdown");
    a_sync_wait: assert property (cfg_write && cfg_mode[1] && !sel_change
        && settle_q == `ASC_SETTLE_FULL && !full_enter
        |=> (settle_q == `ASC_SETTLE_FULL)[*4])
        else $error("settle counted inside sync wait");
    a_settle_step: assert property (settle_q != $past(settle_q)
        && settle_q != `ASC_SETTLE_FULL |-> settle_q == $past(settle_q) - 9'h001)
        else $error("settle counter moved by other than one");
    a_conv_zero: assert property (state_q == asc_pkg::ASC_CONV
        |-> settle_q == 9'h000)
        else $error("conversion before settle reached zero");
    a_ready_zero: assert property (powered && settle_q == 9'h000 && !cfg_write
        |=> state_q == ($past(eff_mode[0]) ? asc_pkg::ASC_CONV : asc_pkg::ASC_STBY))
        else $error("wrong state after settling");
    a_rewrite_keep: assert property (cfg_write && cfg_mode == mode_q
        && !sel_change && !full_enter && cfg_mode[1] && sync_q != 4'h0
        |=> settle_q == $past(settle_q))
        else $error("rewrite changed settle counter");
    a_irq_start: assert property ($rose(state_q == asc_pkg::ASC_CONV)
        && $past(start_pulse_enable) |-> irq_q)
        else $error("no pulse at conversion start");
    a_sel_restart: assert property (sel_change
        |=> restart_q && settle_q == `ASC_SETTLE_FULL && mod_cnt_q == 8'h00)
        else $error("clock select change did not restart");
    a_pin_out: assert property (cfg_write && cfg_clk_sel == `ASC_SEL_OSC_OUT
        |=> pin_oe_q && osc_q)
        else $error("divided clock not driven after write");
    a_full_halt: assert property (full_q && $past(full_q)
        |-> $stable(mod_cnt_q) && $stable(pin_q) && !gate_q)
        else $error("timers ran in full shutdown");
    a_scan_long: assert property (scan_cycle_done && scan_continuous
        && mode_q == `ASC_MODE_CONV && !cfg_write && !full_q
        && scan_delay > `ASC_SCAN_LEAD |=> scan_off_q)
        else $error("long scan delay did not shut down");
    a_scan_short: assert property (scan_cycle_done && scan_continuous
        && mode_q == `ASC_MODE_CONV && !cfg_write && !full_q
        && scan_delay <= `ASC_SCAN_LEAD |=> !scan_off_q)
        else $error("short scan delay shut down");

    c_power_up: cover property ($rose(state_q == asc_pkg::ASC_CONV));
    c_scan_wake: cover property ($fell(scan_off_q) ##[1:600] scan_next_q);
    c_sel_change: cover property (sel_change);
    c_full_shut: cover property ($rose(full_q));

endmodule
